/* File: debug_host_model.sv */
// debugger model driving the access-layer register port
`timescale 1ns/1ps
module debug_host_model
(
   input  wire logic       mclk,
   input  wire logic       brownout_top, // brownout detector at its highest level
   input  wire logic [7:0] reg_rdata,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
   // released lines are inverted so a stale address never looks valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      if (a == 8'h09 && !brownout_top) d = 8'h03;
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge mclk) {reg_wr, reg_addr, reg_wdata} <= {1'b0, ~a, ~d};
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b1, a};
      @(posedge mclk) {reg_rd, reg_addr} <= {1'b0, ~a};
      #1 d = reg_rdata;
   endtask
   // user row data already sits in ram, so final closes the session
   task automatic urow_done(); wr(8'h0a, 8'h03); endtask
   task automatic nvm_done(); wr(8'h08, 8'h59); endtask
endmodule // debug_host_model

/* File: sys_access_pkg.sv */
// package: offsets, field positions, reset values and codes of the system-access registers
package sys_access_pkg;

   // ----------------------------------------------------------------
   // register offsets (internal access-layer address space)
   // ----------------------------------------------------------------
   localparam logic [7:0] RESET_REQUEST_OFS         = 8'h08;
   localparam logic [7:0] PORT_CLOCK_SELECT_OFS     = 8'h09;
   localparam logic [7:0] SYSTEM_ACCESS_CONTROL_OFS = 8'h0a;
   localparam logic [7:0] SYSTEM_ACCESS_STATUS_OFS  = 8'h0b;
   localparam logic [7:0] CRC_CHECK_STATUS_OFS      = 8'h0c;

   // ----------------------------------------------------------------
   // reset values and signatures
   // ----------------------------------------------------------------
   localparam logic [1:0] CLKSEL_RESET        = 2'h3;
   localparam logic [7:0] RESET_SIGNATURE     = 8'h59;
   localparam logic [7:0] STATUS_RESET        = 8'h01;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int CTRL_SYSCLK_REQ_BIT    = 0;
   localparam int CTRL_UROWFIN_BIT       = 1;
   localparam int STAT_LOCK_BIT          = 0;
   localparam int STAT_UROW_READY_BIT    = 2;
   localparam int STAT_NVM_READY_BIT     = 3;
   localparam int STAT_SLEEP_BIT         = 4;
   localparam int STAT_RESET_ACTIVE_BIT  = 5;

   // ----------------------------------------------------------------
   // port clock codes and crc status codes
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      CLK_32MHZ = 2'b00,
      CLK_16MHZ = 2'b01,
      CLK_8MHZ  = 2'b10,
      CLK_4MHZ  = 2'b11
   } port_clock_e;

   localparam logic [2:0] CRC_OFF  = 3'h0;
   localparam logic [2:0] CRC_BUSY = 3'h1;
   localparam logic [2:0] CRC_OK   = 3'h2;
   localparam logic [2:0] CRC_FAIL = 3'h4;

endpackage

/* File: system_access_regs.sv */
// system-access register group of the single-wire debug port
//
// Contract
// R1: clock select codes give 32/16/8/4 MHz
// R2: clock select resets to 4 MHz, 0x03
// R3: debugger keeps 4 MHz unless brownout highest
// R4: writing user_row_final starts user-row programming
// R5: debugger loads user row RAM before final
// R6: user_row_final writable only with key decoded
// R7: clock request holds system clock through sleep
// R8: writing zero withdraws system clock request
// R9: clock request set on enable, cleared disable
// R10: reset-active flag reads reset, cleared by read
// R11: reset held by reset_request also flagged
// R12: in-sleep flag follows idle or deeper sleep
// R13: nvm-ready flag shows nvm programming allowed
// R14: debugger resets system after nvm programming
// R15: user-row-ready flag shows user-row programming allowed
// R16: debugger sets final bit ending user-row session
// R17: lock flag shows lock, resets to one
// R18: crc status is one-hot, reserved codes otherwise
// R19: 0x59 to reset_request asserts reset, else releases
// R20: disabling port resets configuration, drops clock request
// R21: unused bits read zero, ignore writes
`timescale 1ns/1ps

module system_access_regs
   import sys_access_pkg::*;
(
   // clock and reset
   input  wire logic       mclk,
   input  wire logic       rstn,
   // access-layer register port from the link layer
   input  wire logic [7:0] reg_addr,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   input  wire logic [7:0] reg_wdata,
   output logic      [7:0] reg_rdata,
   // port enable state (from the port's disable control)
   input  wire logic       port_enabled,
   // key decoder state
   input  wire logic       user_row_write_key,
   // system domain state
   input  wire logic       sys_in_reset,
   input  wire logic       sys_in_sleep,
   input  wire logic       nvm_prog_allowed,
   input  wire logic       urow_prog_allowed,
   input  wire logic       lock_bits_set,
   input  wire logic       lock_status_valid,
   input  wire logic [2:0] crc_state,
   // controls toward the clock and system domains
   output logic      [1:0] port_clock_select,
   output logic            system_clock_request,
   output logic            system_reset_hold,
   output logic            user_row_final
);

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   wire logic hit_reset_request = (reg_addr == RESET_REQUEST_OFS);
   wire logic hit_clksel = (reg_addr == PORT_CLOCK_SELECT_OFS);
   wire logic hit_ctrl   = (reg_addr == SYSTEM_ACCESS_CONTROL_OFS);
   wire logic hit_status = (reg_addr == SYSTEM_ACCESS_STATUS_OFS);
   wire logic hit_crc    = (reg_addr == CRC_CHECK_STATUS_OFS);

   wire logic wr_reset_request = reg_wr & hit_reset_request;
   wire logic wr_clksel  = reg_wr & hit_clksel;
   wire logic wr_ctrl    = reg_wr & hit_ctrl;
   wire logic rd_status  = reg_rd & hit_status;

   // ----------------------------------------------------------------
   // state registers
   // ----------------------------------------------------------------
   logic [1:0] clksel_reg;
   logic [1:0] clksel_next;
   logic       sysclk_req_reg;
   logic       sysclk_req_next;
   logic       rsthold_reg;
   logic       rsthold_next;
   logic       urowfin_reg;
   logic       urowfin_next;
   logic       reset_seen_reg;
   logic       reset_seen_next;
   logic       enabled_reg;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [7:0] status_view;
   logic [2:0] crc_view;

   // enable edge: request comes up by itself once the port is enabled
   wire logic enable_rise = port_enabled & ~enabled_reg;

   // clock select: any code is legal; disable returns it to 4 MHz
   assign clksel_next = !port_enabled ? CLKSEL_RESET                          // R20
                      : wr_clksel     ? reg_wdata[1:0]                        // R1 R21
                      : clksel_reg;

   // clock request: enable edge sets, disable clears, software writes either way
   assign sysclk_req_next = !port_enabled ? 1'b0                              // R9 R20
                          : enable_rise   ? 1'b1                              // R9
                          : wr_ctrl       ? reg_wdata[CTRL_SYSCLK_REQ_BIT]    // R7 R8
                          : sysclk_req_reg;

   // user-row final: one-cycle start pulse, only with the write key decoded
   assign urowfin_next = wr_ctrl & reg_wdata[CTRL_UROWFIN_BIT]
                       & user_row_write_key & port_enabled;                   // R4 R6

   // reset hold: the signature asserts, any other value releases; port
   // itself is not reset so a held reset survives until rewritten
   assign rsthold_next = wr_reset_request ? (reg_wdata == RESET_SIGNATURE)    // R19
                       : rsthold_reg;

   // sticky reset-active flag; a new reset beats a clearing read
   assign reset_seen_next = (sys_in_reset | rsthold_reg)                      // R10 R11
                          | (reset_seen_reg & ~rd_status);                    // R10

   // lock flag reads one until the lock bits are known to be clear
   wire logic lock_flag = ~lock_status_valid | lock_bits_set;                 // R17

   // crc field passes only legal one-hot codes; reserved codes read as zero
   always_comb
   begin
      unique case (crc_state)
         CRC_BUSY, CRC_OK, CRC_FAIL: crc_view = crc_state;                   // R18
         default:                    crc_view = CRC_OFF;                     // R18
      endcase
   end

   // status view; unused bits stay zero
   always_comb
   begin
      status_view                    = 8'h00;                                // R21
      status_view[STAT_RESET_ACTIVE_BIT] = reset_seen_reg;                   // R10
      status_view[STAT_SLEEP_BIT]        = sys_in_sleep;                     // R12
      status_view[STAT_NVM_READY_BIT]    = nvm_prog_allowed;                 // R13
      status_view[STAT_UROW_READY_BIT]   = urow_prog_allowed;                // R15
      status_view[STAT_LOCK_BIT]     = lock_flag;                            // R17
   end

   // read mux, registered so the data port comes from a flop
   always_comb
   begin
      rdata_next = rdata_reg;
      if (reg_rd)
      begin
         unique case (1'b1)
            hit_reset_request: rdata_next = {7'h00, rsthold_reg};            // R19
            hit_clksel: rdata_next = {6'h00, clksel_reg};                    // R21
            hit_ctrl:   rdata_next = {7'h00, sysclk_req_reg};                // R21
            hit_status: rdata_next = status_view;
            hit_crc:    rdata_next = {5'h00, crc_view};
            default:    rdata_next = 8'h00;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // flops
   // ----------------------------------------------------------------
   // clksel resets to the 4 MHz code
   always_ff @(posedge mclk or negedge rstn)
   begin
      if (!rstn)
      begin
         clksel_reg  <= CLKSEL_RESET;                                        // R2
         sysclk_req_reg <= 1'b0;
         rsthold_reg    <= 1'b0;
         urowfin_reg    <= 1'b0;
         reset_seen_reg <= 1'b0;
         enabled_reg <= 1'b0;
         rdata_reg   <= 8'h00;
      end
      else
      begin
         clksel_reg  <= clksel_next;
         sysclk_req_reg <= sysclk_req_next;
         rsthold_reg    <= rsthold_next;
         urowfin_reg    <= urowfin_next;
         reset_seen_reg <= reset_seen_next;
         enabled_reg <= port_enabled;
         rdata_reg   <= rdata_next;
      end
   end

   // outputs straight from flops
   assign port_clock_select    = clksel_reg;
   assign system_clock_request = sysclk_req_reg;                             // R7
   assign system_reset_hold    = rsthold_reg;                                // R19
   assign user_row_final       = urowfin_reg;
   assign reg_rdata            = rdata_reg;

endmodule // system_access_regs

/* File: system_access_regs_props.sv */
// checker for the system-access register group
`timescale 1ns/1ps
module system_access_regs_props
(
   input wire logic       mclk, rstn, reg_wr, reg_rd, port_enabled, user_row_write_key,
   input wire logic       sys_in_reset, sys_in_sleep, nvm_prog_allowed, urow_prog_allowed,
   input wire logic       lock_bits_set, lock_status_valid, system_clock_request,
   input wire logic       system_reset_hold, user_row_final,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
   input wire logic [2:0] crc_state,
   input wire logic [1:0] port_clock_select
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // decoded strobes and what a status read must capture
   wire       w_ctl  = reg_wr && reg_addr == 8'h0a;
   wire       fin_ok = w_ctl && reg_wdata[1] && user_row_write_key && port_enabled;
   wire [4:0] st_now = {sys_in_sleep, nvm_prog_allowed, urow_prog_allowed, 1'b0,
                        !lock_status_valid | lock_bits_set};
   wire [7:0] crc_ok = crc_state inside {3'h1, 3'h2, 3'h4} ? {5'h0, crc_state} : 8'h0;
   AST_CLKSEL_WR: assert property (reg_wr && reg_addr == 8'h09 && port_enabled |=>
      !port_enabled || port_clock_select == $past(reg_wdata[1:0])) else $error("clksel");
   AST_SYSCLK_REQ_WR: assert property (w_ctl && port_enabled && $past(port_enabled) |=>
      !port_enabled || system_clock_request == $past(reg_wdata[0])) else $error("clock request");
   AST_DISABLE: assert property (!port_enabled |=> !system_clock_request &&
      port_clock_select == 2'h3) else $error("disable");
   AST_FINAL_KEY: assert property (user_row_final |-> $past(fin_ok))
      else $error("final without key");
   AST_FINAL_PULSE: assert property (fin_ok ##1 !fin_ok |->
      user_row_final ##1 !user_row_final) else $error("final pulse");
   AST_RST_HOLD: assert property (reg_wr && reg_addr == 8'h08 |=>
      system_reset_hold == ($past(reg_wdata) == 8'h59)) else $error("reset hold");
   AST_STATUS: assert property (reg_rd && reg_addr == 8'h0b |=>
      reg_rdata[4:0] == $past(st_now) && reg_rdata[7:6] == 2'h0) else $error("status");
   AST_CRC: assert property (reg_rd && reg_addr == 8'h0c |=> reg_rdata == $past(crc_ok))
      else $error("crc");
   cover property (fin_ok);
   cover property (reg_rd && reg_addr == 8'h0b && system_reset_hold);
   cover property ($fell(port_enabled));
endmodule // system_access_regs_props
bind system_access_regs system_access_regs_props system_access_regs_props_inst (.*);

/* File: system_access_regs_tb_top.sv */
// self-checking bench for the system-access register group
`timescale 1ns/1ps
module system_access_regs_tb_top;
   logic       mclk = 0, rstn = 0, port_enabled = 1, user_row_write_key = 0, brownout_top = 1;
   logic       sys_in_reset = 0, sys_in_sleep = 0, nvm_prog_allowed = 0, urow_prog_allowed = 0;
   logic       lock_bits_set = 0, lock_status_valid = 0, reg_wr, reg_rd, user_row_final;
   logic       system_clock_request, system_reset_hold;
   logic [2:0] crc_state = 3'h0;
   logic [1:0] port_clock_select;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, v;
   int         n_mismatch = 0, comparisons = 0, seed = 59298, n_fin = 0, cyc = 0;
   system_access_regs system_access_regs_inst (.*);
   debug_host_model   host (.*);
   initial forever #2 mclk = ~mclk;
   // cycle ceiling cuts a hang short; final pulses tallied here
   always @(posedge mclk)
   begin
      cyc++;
      n_fin += int'(user_row_final === 1'b1);
      if (cyc == 3000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      host.rd(a, v);
      check(v, exp);
   endtask
   function automatic logic [7:0] exp_stat();
      return {3'h0, sys_in_sleep, nvm_prog_allowed, urow_prog_allowed, 1'b0,
              !lock_status_valid | lock_bits_set};
   endfunction
   function automatic logic [7:0] exp_crc(input logic [2:0] c);
      return (c == 3'h1 || c == 3'h2 || c == 3'h4) ? {5'h0, c} : 8'h0;
   endfunction
   task automatic report_and_stop();
      $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
      if (n_mismatch == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   initial
   begin
      repeat (12) @(posedge mclk);
      rstn <= 1;
      rchk(8'h09, 8'h03);
      rchk(8'h0a, 8'h01);
      for (int i = 0; i < 4; i++)
      begin
         host.wr(8'h09, 8'(i));
         #1 check(8'(port_clock_select), 8'(i));
      end
      host.wr(8'h0a, 8'h00);
      #1 check(8'(system_clock_request), 8'h00);
      host.wr(8'h0a, 8'h03);
      #1 check(8'(system_clock_request), 8'h01);
      @(posedge mclk) user_row_write_key <= 1;
      host.urow_done();
      rchk(8'h0a, 8'h01);
      check(8'(n_fin), 8'h01);
      host.nvm_done();
      #1 check(8'(system_reset_hold), 8'h01);
      rchk(8'h08, 8'h01);
      rchk(8'h0b, 8'h21);
      host.wr(8'h08, 8'h58);
      #1 check(8'(system_reset_hold), 8'h00);
      rchk(8'h0b, 8'h21);
      rchk(8'h0b, 8'h01);
      // a reset from the system side itself must also be flagged
      @(posedge mclk) sys_in_reset <= 1;
      rchk(8'h0b, 8'h21);
      @(posedge mclk) sys_in_reset <= 0;
      rchk(8'h0b, 8'h21);
      rchk(8'h0b, 8'h01);
      // random system state; read-only and unmapped places are poked too
      for (int i = 0; i < 24; i++)
      begin
         @(posedge mclk) {sys_in_sleep, nvm_prog_allowed, urow_prog_allowed, lock_bits_set,
                          lock_status_valid, crc_state} <= 8'($random(seed));
         host.wr(8'h0b, 8'hff);
         rchk(8'h0b, exp_stat());
         rchk(8'h0c, exp_crc(crc_state));
         rchk(8'h0d + 8'($random(seed)) % 8'hf3, 8'h00);
      end
      @(posedge mclk) port_enabled <= 0;
      host.wr(8'h09, 8'h00);
      #1 check({port_clock_select, 5'h0, system_clock_request}, 8'hc0);
      @(posedge mclk) port_enabled <= 1;
      repeat (2) @(posedge mclk);
      #1 check(8'(system_clock_request), 8'h01);
      report_and_stop();
   end
endmodule // system_access_regs_tb_top
